// ===== psi_ctl.sv
// Controller end: AHB-Lite registers driving the serial bus and
// refresh bursts around powerdown. Assumes one device on the link.
`timescale 1ns/100ps
module psi_ctl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  psi_link_if.ctl          lnk
);
  import psi_pkg::*;
`include "psi_defines.svh"

  typedef struct packed {
    logic        sck;
    logic [7:0]  div;
    logic        srst_n;
    logic        scmd_n;
    logic        req_v;
    psi_req_e    req_c;
    logic [2:0]  req_b;
    logic        clk_run;
    psi_seq_e    seq;
    logic [15:0] tmr;
    logic [7:0]  cnt;
    logic [15:0] ref_i;
    logic [15:0] ref_n;
    logic        exiting;
    logic        pre;
    logic [16:0] sh;
    logic [1:0]  ret_s;
    logic        powerdown_entry_cmd;
    logic        ap_v;
    logic        ap_wr;
    logic [7:0]  ap_off;
    logic [31:0] rdata;
    logic        rdy;
  } psi_ctl_s;

  psi_ctl_s q;
  psi_ctl_s d;

  always_comb begin
    logic rise;
    logic tick;
    rise = 1'b0;
    tick = 1'b0;
    d = q;
    d.req_v = 1'b0;
    d.req_c = REQ_NONE;
    d.ret_s = {q.ret_s[0], ~lnk.chain_out_n}; // [R16]
    // ****************************************
    // Serial clock divider
    // ****************************************
    tick = (q.div == `PSI_SCK_HALF - 8'h01);
    d.div = tick ? 8'h00 : q.div + 8'h01;
    if (tick) begin
      d.sck = ~q.sck;
    end
    // Outputs change on rising edges; the device samples on falling
    rise = tick && !q.sck;
    // ****************************************
    // Sequencer
    // ****************************************
    unique case (q.seq)
      SEQ_IDLE: ;
      SEQ_INIT: begin
        if (rise) begin
          d.cnt = q.cnt + 8'h01;
          d.srst_n = !(q.cnt < `PSI_RST_HI); // [R20]
          if (q.cnt == `PSI_INIT_END) begin
            d.seq = SEQ_IDLE;
          end
        end
      end
      SEQ_REF: begin
        d.req_v = 1'b1;
        d.req_b = q.ref_i[2:0];
        if (!q.pre) begin
          d.pre = 1'b1;
          d.req_c = (q.exiting && q.ref_i[2:0] == 3'h7) ? REQ_REF_INC
                                                         : REQ_REF_ACT;
        end else begin
          d.pre = 1'b0;
          d.req_c = REQ_REF_PRE;
          d.ref_i = q.ref_i + 16'h0001;
          if (q.ref_i == q.ref_n - 16'h0001) begin
            d.seq = q.exiting ? SEQ_IDLE : SEQ_GAP;
            d.tmr = 16'(`PSI_CYC(`PSI_CMD_PDN_NS));
          end
        end
      end
      SEQ_GAP: begin
        if (q.tmr <= 16'h0001) begin
          d.req_v = 1'b1;
          d.req_c = REQ_PDN; // [R3]
          d.seq = SEQ_CLKW;
          d.tmr = 16'(`PSI_CYC(`PSI_PDN_CFM_NS));
        end else begin
          d.tmr = q.tmr - 16'h0001;
        end
      end
      SEQ_CLKW: begin
        if (q.tmr <= 16'h0001) begin
          d.clk_run = 1'b0; // [R5]
          d.powerdown_entry_cmd = 1'b1;
          d.seq = SEQ_IDLE;
        end else begin
          d.tmr = q.tmr - 16'h0001;
        end
      end
      SEQ_CFM: begin
        if (q.tmr <= 16'h0001) begin
          d.seq = SEQ_SBW; // [R11]
          d.cnt = 8'h00;
          d.sh = {1'b1, `PSI_PM_ADDR, `PSI_PX_VALUE}; // [R8]
        end else begin
          d.tmr = q.tmr - 16'h0001;
        end
      end
      SEQ_SBW: begin
        if (rise) begin
          d.cnt = q.cnt + 8'h01;
          d.scmd_n = ~q.sh[16];
          d.sh = {q.sh[15:0], 1'b0};
          if (q.cnt == 8'h11) begin
            d.scmd_n = 1'b1;
            d.seq = SEQ_XGAP;
            // Margin of one serial half period already covered
            d.tmr = 16'(`PSI_CYC(`PSI_PDN_CMD_NS));
          end
        end
      end
      SEQ_XGAP: begin
        if (q.tmr <= 16'h0001) begin
          d.seq = SEQ_REF; // [R12]
          d.powerdown_entry_cmd = 1'b0;
          d.ref_i = 16'h0000;
          d.ref_n = 16'(8 + `PSI_EXTRA_REF); // [R13] [R15]
        end else begin
          d.tmr = q.tmr - 16'h0001;
        end
      end
    endcase
    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    if (q.ap_v && q.ap_wr && q.ap_off == `PSI_REG_CMD &&
        q.seq == SEQ_IDLE) begin
      // Orders given while busy are dropped on purpose
      unique case (hwdata[2:0])
        `PSI_OP_INIT: begin
          d.seq = SEQ_INIT;
          d.cnt = 8'h00;
        end
        `PSI_OP_ENTER: begin
          d.seq = SEQ_REF; // [R2]
          d.exiting = 1'b0;
          d.pre = 1'b0;
          d.ref_i = 16'h0000;
          d.ref_n = 16'h0008;
        end
        `PSI_OP_EXIT: begin
          d.seq = SEQ_CFM;
          d.clk_run = 1'b1; // [R11]
          d.exiting = 1'b1;
          d.pre = 1'b0;
          d.tmr = 16'(`PSI_CYC(`PSI_CFM_PDN_NS));
        end
        default: ;
      endcase
    end
    d.ap_v = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      d.ap_wr = hwrite;
      d.ap_off = haddr[7:0];
      d.rdata = 32'h0000_0000;
      if (haddr[7:0] == `PSI_REG_STATUS) begin
        d.rdata = {28'h0000000, q.powerdown_entry_cmd, q.ret_s[1], q.clk_run,
                   q.seq != SEQ_IDLE};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.srst_n <= 1'b1; // [R17]
      q.scmd_n <= 1'b1; // [R17]
      q.clk_run <= 1'b1;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hreadyout        = q.rdy;
  assign hrdata           = q.rdata;
  assign hresp            = 1'b0;
  assign lnk.sclk         = q.sck;
  assign lnk.srst_n       = q.srst_n;
  assign lnk.scmd_n       = q.scmd_n;
  assign lnk.req_valid    = q.req_v;
  assign lnk.req_cmd      = q.req_c;
  assign lnk.req_bank     = q.req_b;
  assign lnk.core_clk_run = q.clk_run;
endmodule : psi_ctl

// ===== psi_defines.svh
// Constants for the powerdown and serial id blocks.
// Assumes a 100 MHz hclk in both ends.
`ifndef PSI_DEFINES_SVH
`define PSI_DEFINES_SVH
// ****************************************
// Device register and serial frame
// ****************************************
`define PSI_PM_ADDR       8'h03
`define PSI_PM_RESET      8'h00
`define PSI_PX_VALUE      8'h01
`define PSI_PX_BIT        0
`define PSI_FRAME_BITS    5'h10
`define PSI_ID_MAX        6'h3f
// ****************************************
// Timing in ns and derived hclk cycles
// ****************************************
`define PSI_CLK_NS        10
`define PSI_PDN_ENTRY_NS  200
`define PSI_PDN_EXIT_NS   200
`define PSI_PDN_CMD_NS    300
`define PSI_CMD_PDN_NS    100
`define PSI_PDN_CFM_NS    100
`define PSI_CFM_PDN_NS    100
`define PSI_SELFREF_NS    800
`define PSI_TREF_NS       32000000
`define PSI_CYC(ns) (((ns) + `PSI_CLK_NS - 1) / `PSI_CLK_NS)
`define PSI_EXTRA_REF \
  ((8 * 4096 * `PSI_PDN_CMD_NS + `PSI_TREF_NS - 1) / `PSI_TREF_NS)
// ****************************************
// Controller serial clock and registers
// ****************************************
`define PSI_SCK_HALF      8'h06
`define PSI_RST_HI        8'h04
`define PSI_INIT_END      8'h48
`define PSI_REG_CMD       8'h00
`define PSI_REG_STATUS    8'h04
`define PSI_OP_INIT       3'h1
`define PSI_OP_ENTER      3'h2
`define PSI_OP_EXIT       3'h3
`endif

// ===== psi_dev.sv
// Device end: power states, self refresh and serial chain id.
// Assumes the controller end keeps its sequencing duties.
//
// Summary of operation
// R1: Two power states; powerdown self refreshes.
// R2: Controller refreshes all banks before entry.
// R3: Controller waits, then sends entry command.
// R4: Enter powerdown after entry interval.
// R5: Core clock stops only after set interval.
// R6: Self refresh steps bank pointer through eight.
// R7: Bank pointer wrap advances row counter.
// R8: Exit starts with broadcast write of one.
// R9: Exit bit returns device to active.
// R10: Active once exit interval after write.
// R11: Core clock stable before write ends.
// R12: Silence after exit, then refresh activate.
// R13: Eight refreshes after exit, last increments.
// R14: No self refresh after exit write.
// R15: Extra m refreshes, every eighth increments.
// R16: Serial pins low-true, chained toward controller.
// R17: Reset and command held zero before init.
// R18: Serial inputs sampled on falling clock.
// R19: First reset sample loads reset values.
// R20: Reset held one at least two cycles.
// R21: Chain output one a cycle after reset.
// R22: Chain output zero a cycle after input.
// R23: Cycles from release to input zero: id.
// R24: Increment refresh uses row, then advances.
//
// Added by the designer: the AHB-Lite interface to the registers, at the controller end.
`timescale 1ns/100ps
module psi_dev (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  psi_link_if.dev          lnk,
  output logic             power_active,
  output logic             ref_pulse,
  output logic [2:0]       ref_bank,
  output logic [11:0]      ref_row,
  output logic [5:0]       chain_id,
  output logic             chain_id_valid,
  output logic [7:0]       pm_value
);
  import psi_pkg::*;
`include "psi_defines.svh"

  typedef struct packed {
    logic [2:0]  sck_s;
    logic [1:0]  rst_s;
    logic [1:0]  cmd_s;
    logic [1:0]  cin_s;
    logic        rst_prev;
    logic [1:0]  rst_hi;
    logic        chain_out_n;
    logic        id_arm;
    logic [5:0]  id_cnt;
    logic [5:0]  id;
    logic        id_valid;
    logic        drop_pend;
    logic        sh_act;
    logic [4:0]  sh_cnt;
    logic [15:0] sh;
    logic [7:0]  pm;
    psi_pwr_e    pwr;
    logic [15:0] tmr;
    logic [15:0] ref_tmr;
    logic [2:0]  bank;
    logic [11:0] row;
    logic        ref_p;
    logic [2:0]  ref_b;
    logic [11:0] ref_r;
    logic        active;
  } psi_dev_s;

  psi_dev_s q;
  psi_dev_s d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic        fall;
    logic        rst;
    logic        cin;
    logic        cmd;
    logic        release_now;
    logic [5:0]  cnt_now;
    logic [15:0] word;
    fall = 1'b0;
    rst = 1'b0;
    cin = 1'b0;
    cmd = 1'b0;
    release_now = 1'b0;
    cnt_now = 6'h00;
    word = 16'h0000;
    d = q;
    d.ref_p = 1'b0;
    // Reset, command and chain pins are low-true: store the logical level after two flops
    d.sck_s = {q.sck_s[1:0], lnk.sclk};
    d.rst_s = {q.rst_s[0], ~lnk.srst_n};
    d.cmd_s = {q.cmd_s[0], ~lnk.scmd_n};
    d.cin_s = {q.cin_s[0], ~lnk.chain_in_n}; // [R16]
    fall = q.sck_s[2] & ~q.sck_s[1]; // [R18]
    rst = q.rst_s[1];
    cmd = q.cmd_s[1];
    cin = q.cin_s[1];
    word = {q.sh[14:0], cmd};

    // ****************************************
    // Power states and refresh
    // ****************************************
    unique case (q.pwr)
      PWR_ACTIVE: begin
        if (lnk.req_valid) begin
          unique case (lnk.req_cmd)
            REQ_REF_ACT: begin
              d.ref_p = 1'b1;
              d.ref_b = lnk.req_bank;
              d.ref_r = q.row;
            end
            REQ_REF_INC: begin
              d.ref_p = 1'b1;
              d.ref_b = lnk.req_bank;
              d.ref_r = q.row;
              d.row = q.row + 12'h001; // [R24]
            end
            REQ_PDN: begin
              d.pwr = PWR_ENTRY;
              d.tmr = 16'(`PSI_CYC(`PSI_PDN_ENTRY_NS)); // [R4]
              d.pm[`PSI_PX_BIT] = 1'b0;
            end
            default: ;
          endcase
        end
      end
      PWR_ENTRY: begin
        if (q.tmr <= 16'h0001) begin
          d.pwr = PWR_DOWN; // [R4]
          d.active = 1'b0;
          d.ref_tmr = 16'(`PSI_CYC(`PSI_SELFREF_NS));
        end else begin
          d.tmr = q.tmr - 16'h0001;
        end
      end
      PWR_DOWN: begin
        // Internal time source; core clock may be stopped here
        if (q.ref_tmr <= 16'h0001) begin
          d.ref_tmr = 16'(`PSI_CYC(`PSI_SELFREF_NS));
          d.ref_p = 1'b1; // [R1]
          d.ref_b = q.bank; // [R6]
          d.ref_r = q.row;
          d.bank = q.bank + 3'h1; // [R6]
          if (q.bank == 3'h7) begin
            d.row = q.row + 12'h001; // [R7]
          end
        end else begin
          d.ref_tmr = q.ref_tmr - 16'h0001;
        end
      end
      PWR_EXIT: begin
        // Self refresh already stopped at the end of the write
        if (q.tmr <= 16'h0001) begin
          d.pwr = PWR_ACTIVE; // [R10]
          d.active = 1'b1;
        end else begin
          d.tmr = q.tmr - 16'h0001;
        end
      end
    endcase

    // ****************************************
    // Serial bus, sampled on falling edges
    // ****************************************
    if (fall) begin
      d.rst_prev = rst;
      if (rst) begin
        d.rst_hi = (q.rst_hi == 2'h3) ? q.rst_hi : q.rst_hi + 2'h1;
        if (!q.rst_prev) begin
          d.rst_hi = 2'h0;
          d.pm = `PSI_PM_RESET; // [R19]
          d.pwr = PWR_DOWN; // [R19]
          d.active = 1'b0;
          d.ref_tmr = 16'(`PSI_CYC(`PSI_SELFREF_NS));
          d.id_valid = 1'b0;
          d.id_arm = 1'b0;
          d.drop_pend = 1'b0;
          d.sh_act = 1'b0;
        end else begin
          d.chain_out_n = 1'b0; // [R21]
        end
      end else begin
        // A short reset pulse does not start id discovery
        release_now = q.rst_prev && (q.rst_hi != 2'h0);
        cnt_now = release_now ? 6'h00 : q.id_cnt;
        if (q.drop_pend) begin
          d.chain_out_n = 1'b1; // [R22]
          d.drop_pend = 1'b0;
        end
        if ((release_now || q.id_arm) && !q.id_valid) begin
          if (!cin) begin
            d.id = cnt_now; // [R23]
            d.id_valid = 1'b1;
            d.id_arm = 1'b0;
            d.drop_pend = 1'b1; // [R22]
          end else begin
            d.id_arm = 1'b1;
            d.id_cnt = (cnt_now == `PSI_ID_MAX) ? cnt_now
                                                : cnt_now + 6'h01; // [R23]
          end
        end
        if (!q.sh_act) begin
          if (cmd) begin
            d.sh_act = 1'b1;
            d.sh_cnt = 5'h00;
          end
        end else begin
          d.sh = word;
          d.sh_cnt = q.sh_cnt + 5'h01;
          if (q.sh_cnt == `PSI_FRAME_BITS - 5'h01) begin
            d.sh_act = 1'b0;
            if (word[15:8] == `PSI_PM_ADDR) begin
              d.pm = word[7:0];
              if (word[`PSI_PX_BIT] && q.pwr != PWR_ACTIVE) begin
                d.pwr = PWR_EXIT; // [R9]
                d.tmr = 16'(`PSI_CYC(`PSI_PDN_EXIT_NS)); // [R10]
              end
              // Leaving powerdown halts self refresh at once
              d.ref_tmr = 16'(`PSI_CYC(`PSI_SELFREF_NS)); // [R14]
            end
          end
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.chain_out_n <= 1'b1;
      q.pwr <= PWR_DOWN;
      q.pm <= `PSI_PM_RESET;
    end else begin
      q <= d;
    end
  end

  assign lnk.chain_out_n  = q.chain_out_n;
  assign power_active     = q.active;
  assign ref_pulse        = q.ref_p;
  assign ref_bank         = q.ref_b;
  assign ref_row          = q.ref_r;
  assign chain_id         = q.id;
  assign chain_id_valid   = q.id_valid;
  assign pm_value         = q.pm;
endmodule : psi_dev

// ===== psi_link_asserts.sv
// Checker for the serial and request link between the two ends.
// Assumes the bench hands it the link signals and the hclk domain.
`timescale 1ns/100ps
`include "psi_defines.svh"
module psi_link_asserts (
  input logic              hclk,
  input logic              hresetn,
  input logic              sclk,
  input logic              srst_n,
  input logic              scmd_n,
  input logic              chain_in_n,
  input logic              chain_out_n,
  input logic              req_valid,
  input psi_pkg::psi_req_e req_cmd,
  input logic [2:0]        req_bank,
  input logic              core_clk_run
);
  import psi_pkg::*;
  // ****************************************
  // Helper counters and flags
  // ****************************************
  localparam int GAP = `PSI_CYC(`PSI_PDN_CMD_NS) - 1;
  logic [9:0] lo_cnt;
  logic [9:0] quiet_cnt;
  logic [9:0] sc_cnt;
  logic       exit_pend;
  logic       in_exit;
  logic [2:0] act_bank;
  // Saturate so a long idle stretch never wraps back under a bound
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_cnt    <= '0;
      quiet_cnt <= '0;
      sc_cnt    <= '0;
      exit_pend <= 1'b0;
      in_exit   <= 1'b0;
      act_bank  <= '0;
    end else begin
      lo_cnt    <= srst_n ? '0 : lo_cnt + {9'h0, ~&lo_cnt};
      quiet_cnt <= req_valid ? '0 : quiet_cnt + {9'h0, ~&quiet_cnt};
      sc_cnt    <= !scmd_n ? '0 : sc_cnt + {9'h0, ~&sc_cnt};
      if ($fell(scmd_n)) begin
        exit_pend <= 1'b1;
      end else if (req_valid) begin
        exit_pend <= 1'b0;
      end
      if ($fell(scmd_n)) begin
        in_exit <= 1'b1;
      end else if (req_valid && req_cmd == REQ_PDN) begin
        in_exit <= 1'b0;
      end
      if (req_valid && req_cmd inside {REQ_REF_ACT, REQ_REF_INC}) begin
        act_bank <= req_bank;
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pdn;
    req_valid && req_cmd == REQ_PDN;
  endsequence
  sequence s_act;
    req_valid && req_cmd inside {REQ_REF_ACT, REQ_REF_INC};
  endsequence
  a_rst_long: assert property ($rose(srst_n) |-> lo_cnt >= 24)
    else $error("serial reset pulse too short");
  a_pdn_quiet: assert property (s_pdn |-> quiet_cnt >= 9)
    else $error("entry command too soon");
  a_clk_hold: assert property (
    s_pdn |-> core_clk_run [*8] ##1 core_clk_run)
    else $error("core clock stopped early");
  a_clk_first: assert property (
    $fell(scmd_n) |-> core_clk_run && $past(core_clk_run, 10))
    else $error("core clock late for exit write");
  a_cmd_idle: assert property (!srst_n |-> scmd_n)
    else $error("command line active in reset");
  a_exit_first: assert property (
    req_valid && exit_pend |-> req_cmd == REQ_REF_ACT && sc_cnt >= GAP)
    else $error("bad first request after exit");
  a_inc_last: assert property (
    req_valid && req_cmd == REQ_REF_INC |-> req_bank == 3'h7 && in_exit)
    else $error("increment refresh misplaced");
  a_act_pre: assert property (
    s_act |-> ##[1:4] (req_valid && req_cmd == REQ_REF_PRE &&
                       req_bank == act_bank))
    else $error("refresh not closed");
  a_out_set: assert property (
    $fell(srst_n) |-> chain_out_n [*8] ##1 chain_out_n [*6]
                      ##[1:14] !chain_out_n)
    else $error("chain output not raised");
  a_out_clear: assert property (
    $rose(chain_in_n) |-> !chain_out_n [*8] ##[4:22] chain_out_n)
    else $error("chain output not released");
endmodule : psi_link_asserts

// ===== psi_link_if.sv
// Link between controller and one device: serial bus and requests.
// Serial pins carry low-true levels; the bench drives chain_in_n.
`timescale 1ns/100ps
interface psi_link_if;
  import psi_pkg::*;
  logic           sclk;
  logic           srst_n;
  logic           scmd_n;
  logic           chain_in_n;
  logic           chain_out_n;
  logic           req_valid;
  psi_req_e       req_cmd;
  logic [2:0]     req_bank;
  logic           core_clk_run;
  modport dev (input sclk, srst_n, scmd_n, chain_in_n, req_valid,
               req_cmd, req_bank, core_clk_run, output chain_out_n);
  modport ctl (output sclk, srst_n, scmd_n, req_valid, req_cmd,
               req_bank, core_clk_run, input chain_out_n);
endinterface : psi_link_if

// ===== psi_pkg.sv
// Shared types for the powerdown and serial id blocks.
// Assumes nothing beyond the defines header.
package psi_pkg;
  typedef enum logic [2:0] {
    REQ_NONE, REQ_REF_ACT, REQ_REF_INC, REQ_REF_PRE, REQ_PDN
  } psi_req_e;
  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_ENTRY, PWR_DOWN, PWR_EXIT
  } psi_pwr_e;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_INIT, SEQ_REF, SEQ_GAP, SEQ_CLKW, SEQ_CFM, SEQ_SBW,
    SEQ_XGAP
  } psi_seq_e;
endpackage : psi_pkg

// ===== psi_tb_top.sv
// Bench joining controller and device over one link.
// Assumes a single device; the bench plays the upstream chain input.
`timescale 1ns/100ps
`include "psi_defines.svh"
module psi_tb_top;
  import psi_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        power_active;
  logic        ref_pulse;
  logic [2:0]  ref_bank;
  logic [11:0] ref_row;
  logic [5:0]  chain_id;
  logic        chain_id_valid;
  logic [7:0]  pm_value;
  logic [11:0] last_row;
  logic [11:0] prev_row;
  logic [31:0] rd;
  int          fails;
  int          cmp_count;
  int          seed;
  psi_link_if lnk ();
  psi_dev psi_dev_i (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.dev),
    .power_active(power_active), .ref_pulse(ref_pulse),
    .ref_bank(ref_bank), .ref_row(ref_row), .chain_id(chain_id),
    .chain_id_valid(chain_id_valid), .pm_value(pm_value));
  psi_ctl psi_ctl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .lnk(lnk.ctl));
  psi_link_asserts psi_link_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .sclk(lnk.sclk), .srst_n(lnk.srst_n), .scmd_n(lnk.scmd_n),
    .chain_in_n(lnk.chain_in_n), .chain_out_n(lnk.chain_out_n),
    .req_valid(lnk.req_valid), .req_cmd(lnk.req_cmd),
    .req_bank(lnk.req_bank), .core_clk_run(lnk.core_clk_run));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (ref_pulse === 1'b1) begin
      prev_row <= last_row;
      last_row <= ref_row;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task finish_test;
    $display("TB: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task lost;
    fails++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    finish_test;
  endtask : lost
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) lost();
    rd = hrdata;
  endtask : xfer
  task wait_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `PSI_REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 4000);
    if (n >= 4000) lost();
  endtask : wait_idle
  task wait_ref;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (ref_pulse !== 1'b1 && n < 400);
    if (n >= 400) lost();
  endtask : wait_ref
  task sck_rises(input int cnt);
    int n;
    int seen;
    logic p;
    n = 0;
    seen = 0;
    p = lnk.sclk;
    while (seen < cnt && n < 2000) begin
      @(posedge hclk);
      n++;
      if (lnk.sclk === 1'b1 && p === 1'b0) seen++;
      p = lnk.sclk;
    end
    if (seen < cnt) lost();
  endtask : sck_rises
  task self_ref(input logic [11:0] r0, input logic use_r0);
    logic [2:0]  b;
    logic [11:0] r;
    wait_ref();
    b = ref_bank;
    r = ref_row;
    if (use_r0) chk(r, r0);
    repeat (9) begin
      wait_ref();
      r = (b == 3'h7) ? r + 12'h1 : r;
      b = b + 3'h1;
      chk(ref_bank, b);
      chk(ref_row, r);
    end
  endtask : self_ref
  task run_init(input int k);
    int n;
    lnk.chain_in_n <= 1'b0;
    xfer(1'b1, `PSI_REG_CMD, `PSI_OP_INIT);
    n = 0;
    while (lnk.srst_n !== 1'b0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    while (lnk.srst_n !== 1'b1 && n < 1500) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 1500) lost();
    // Upstream release lands k link cycles after ours: we sit at k
    sck_rises(k);
    lnk.chain_in_n <= 1'b1;
    wait_idle();
    chk(chain_id, k);
    chk(chain_id_valid, 1);
    chk(pm_value, `PSI_PM_RESET);
    chk(power_active, 0);
    chk(rd[2], 0);
    self_ref(12'h0, 1'b0);
  endtask : run_init
  task exit_seq;
    xfer(1'b1, `PSI_REG_CMD, `PSI_OP_EXIT);
    wait_idle();
    chk(power_active, 1);
    chk(pm_value, `PSI_PX_VALUE);
    chk(rd[3], 0);
    chk(ref_bank, (8 + `PSI_EXTRA_REF - 1) % 8);
    chk(ref_row, prev_row + 12'h1);
  endtask : exit_seq
  task enter_seq;
    xfer(1'b1, `PSI_REG_CMD, `PSI_OP_ENTER);
    // Second order lands while busy and must be dropped
    xfer(1'b1, `PSI_REG_CMD, `PSI_OP_EXIT);
    wait_idle();
    repeat (`PSI_CYC(`PSI_PDN_ENTRY_NS)) @(posedge hclk);
    chk(power_active, 0);
    chk(rd[1], 0);
    chk(rd[3], 1);
    self_ref(last_row, 1'b1);
  endtask : enter_seq
  initial begin
    seed = 69;
    fails = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    lnk.chain_in_n = 1'b0;
    last_row = '0;
    prev_row = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(power_active, 0);
    xfer(1'b1, 32'h10, 32'hffff_ffff);
    xfer(1'b0, 32'h10, 32'h0);
    chk(rd, 0);
    xfer(1'b0, `PSI_REG_STATUS, 32'h0);
    chk(rd[1:0], 2'b10);
    chk(hresp, 1'b0);
    $display("TEST reset done");
    run_init(0);
    run_init(63);
    run_init({$random(seed)} % 62 + 1);
    $display("TEST init done");
    repeat (2) begin
      repeat ({$random(seed)} % 8) @(posedge hclk);
      exit_seq();
      enter_seq();
    end
    $display("TEST power done");
    finish_test();
  end
endmodule : psi_tb_top
